// ==== tb_watchdog_two_write_unlock.sv ====
// self-checking bench for the watchdog top with its AXI4-Lite register slave
// assumes one 25 MHz clock, a bus master in this bench, and the tap input driven fast
`timescale 1ns/100ps
`include "watchdog_regs.svh"
module tb_watchdog_two_write_unlock;
  import wdt_pkg::*;
  // =====================================================
  // signals
  logic   clock;
  logic   reset_n;
  logic   clock_enable;
  logic   time_base_tap_256hz;
  logic   awvalid, awready, wvalid, wready, bvalid, bready;
  logic   arvalid, arready, rvalid, rready;
  addr_t  awaddr, araddr;
  data_t  wdata, rdata, rd;
  strb_t  wstrb;
  resp_t  bresp, rresp, rs;
  logic   watchdog_irq, irq;
  int     fail_count, checks_done, pulse_count;
  localparam addr_t A_UNLOCK = {2'b00, `WDT_IDX_UNLOCK, 2'b00};
  localparam addr_t A_STATUS = {2'b00, `WDT_IDX_STATUS, 2'b00};
  localparam addr_t A_MASK   = {2'b00, `WDT_IDX_MASK, 2'b00};
  localparam addr_t A_STATE  = {2'b00, `WDT_IDX_STATE, 2'b00};
  localparam addr_t A_HOLE   = 16'h0010;

  watchdog_two_write_unlock dut (.clock(clock), .reset_n(reset_n), .clock_enable(clock_enable),
    .time_base_tap_256hz(time_base_tap_256hz), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .watchdog_irq(watchdog_irq), .irq(irq));

  always #20 clock = ~clock;
  // counts every cycle the pulse is high, so a stretched pulse is caught too
  always @(posedge clock)
  begin
    if (watchdog_irq === 1'b1)
      pulse_count++;
  end

  // =====================================================
  // helpers
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_c(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic axi_write(input addr_t a, input data_t d, output resp_t r);
    int n;
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    n = 0;
    @(posedge clock);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    while (!(aw_done && w_done) && n < 50)
    begin
      @(posedge clock);
      n++;
      if (!aw_done && awready === 1'b1)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (bvalid !== 1'b1 && n < 100);
    r = bresp;
    bready <= 1'b0;
    check("write handshake", n < 100, 1'b1);
  endtask

  task automatic axi_read(input addr_t a, output data_t d, output resp_t r);
    int n;
    n = 0;
    @(posedge clock);
    arvalid <= 1'b1;
    araddr <= a;
    while (arready !== 1'b1 && n < 50)
    begin
      @(posedge clock);
      n++;
    end
    @(posedge clock);
    arvalid <= 1'b0;
    rready <= 1'b1;
    while (rvalid !== 1'b1 && n < 100)
    begin
      @(posedge clock);
      n++;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    check("read handshake", n < 100, 1'b1);
  endtask

  task automatic key(input logic [3:0] v);
    axi_write(A_UNLOCK, {28'h000_0000, v}, rs);
  endtask

  task automatic expect_state(input string name, input logic [8:0] cnt, input logic run, input logic ptr);
    axi_read(A_STATE, rd, rs);
    check(name, rd, {21'h00_0000, ptr, run, cnt});
  endtask

  // each tap is one rising edge of the tap level
  task automatic tap_n(input int n);
    repeat (n)
    begin
      @(posedge clock);
      time_base_tap_256hz <= 1'b1;
      wait_c(2);
      time_base_tap_256hz <= 1'b0;
      wait_c(1);
    end
    wait_c(3);
  endtask

  // =====================================================
  // scenarios
  task automatic t_reset();
    check("irq after reset", {watchdog_irq, irq}, 2'b00);
    expect_state("state after reset", 9'h000, 1'b0, 1'b0);
    axi_read(A_UNLOCK, rd, rs);
    check("unlock port reads zero", rd, `WDT_DATA_ZERO);
    check("unlock port read resp", rs, RESP_OKAY);
    axi_read(A_HOLE, rd, rs);
    check("unmapped read", rd, `WDT_DATA_ZERO);
    check("unmapped read resp", rs, RESP_DECERR);
    axi_write(A_HOLE, 32'h0000_0005, rs);
    check("unmapped write", rs, RESP_DECERR);
    tap_n(3);
    expect_state("stopped after reset", 9'h000, 1'b0, 1'b0);
  endtask

  task automatic t_start();
    key(`WDT_KEY_FIRST);
    expect_state("pointer after first key", 9'h000, 1'b0, 1'b1);
    key(`WDT_KEY_SECOND);
    wait_c(3);
    expect_state("started by pair", 9'h000, 1'b1, 1'b0);
    axi_read(A_STATUS, rd, rs);
    check("accept event", rd[`WDT_EV_ACCEPT], 1'b1);
    axi_write(A_STATUS, 32'h0000_0007, rs);
    tap_n(5);
    expect_state("count of five taps", 9'h005, 1'b1, 1'b0);
    key(`WDT_KEY_FIRST);
    key(`WDT_KEY_SECOND);
    wait_c(3);
    expect_state("cleared by pair", 9'h000, 1'b1, 1'b0);
  endtask

  task automatic t_reject();
    tap_n(2);
    key(`WDT_KEY_FIRST);
    key(`WDT_KEY_FIRST);
    key(`WDT_KEY_SECOND);
    wait_c(3);
    expect_state("out of step pair", 9'h002, 1'b1, 1'b1);
    axi_read(A_STATUS, rd, rs);
    check("reject event", rd[`WDT_EV_REJECT], 1'b1);
    key(4'h0);
    expect_state("any value toggles", 9'h002, 1'b1, 1'b0);
  endtask

  task automatic t_overflow();
    key(`WDT_KEY_FIRST);
    key(`WDT_KEY_SECOND);
    wait_c(3);
    key(`WDT_KEY_FIRST);
    pulse_count = 0;
    tap_n(511);
    expect_state("top value", `WDT_COUNT_MAX, 1'b1, 1'b1);
    check("no early overflow", pulse_count, 0);
    tap_n(1);
    check("one overflow pulse", pulse_count, 1);
    check("masked level", irq, 1'b0);
    expect_state("wrapped and running", `WDT_COUNT_RESET, 1'b1, 1'b0);
    axi_read(A_STATUS, rd, rs);
    check("overflow event", rd[`WDT_EV_OVERFLOW], 1'b1);
    tap_n(1);
    expect_state("runs on after wrap", 9'h001, 1'b1, 1'b0);
  endtask

  task automatic t_irq();
    axi_write(A_MASK, 32'h0000_0001, rs);
    wait_c(3);
    check("unmasked level", irq, 1'b1);
    axi_read(A_MASK, rd, rs);
    check("mask readback", rd, 32'h0000_0001);
    axi_write(A_STATUS, 32'h0000_0001, rs);
    wait_c(3);
    check("level after clear", irq, 1'b0);
    axi_read(A_STATUS, rd, rs);
    check("status after clear", rd[`WDT_EV_OVERFLOW], 1'b0);
    axi_write(A_MASK, 32'h0000_0000, rs);
    check("never masked pulse", pulse_count, 1);
  endtask

  // =====================================================
  // main sequence and watchdog
  initial
  begin
    clock = 1'b0;
    reset_n = 1'b0;
    clock_enable = 1'b1;
    time_base_tap_256hz = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = `WDT_DATA_ZERO;
    wstrb = 4'h0;
    fail_count = 0;
    checks_done = 0;
    pulse_count = 0;
    wait_c(5);
    reset_n <= 1'b1;
    wait_c(1);
    t_reset();
    t_start();
    t_reject();
    t_overflow();
    t_irq();
    finish_test();
  end

  initial
  begin
    #(40 * 20000);
    fail_count++;
    finish_test();
  end
endmodule

// ==== unlock_sequencer.sv ====
// two-write key sequencer with toggling pointer
// assumes write_pulse is already gated by the clock enable
`timescale 1ns/100ps
`include "watchdog_regs.svh"
module unlock_sequencer (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_enable,
  wdt_link_if.seq  link
);
  import wdt_pkg::*;
  logic first_ok;
  logic pair_ok;

  // =====================================================
  // pointer and first key
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      link.pointer <= 1'b0;
    else if (clock_enable)
    begin
      if (link.overflow)
        link.pointer <= 1'b0;
      else if (link.write_pulse)
        link.pointer <= ~link.pointer;
    end

  // a first key seen at pointer 1 never arms the pair
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      first_ok <= 1'b0;
    else if (clock_enable)
    begin
      if (link.overflow)
        first_ok <= 1'b0;
      else if (link.write_pulse)
        first_ok <= !link.pointer && link.write_data == `WDT_KEY_FIRST;
    end

  assign pair_ok = link.write_pulse && link.pointer && first_ok &&
                   link.write_data == `WDT_KEY_SECOND && !link.overflow;

  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      link.accept   <= 1'b0;
      link.rejected <= 1'b0;
    end
    else if (clock_enable)
    begin
      link.accept   <= pair_ok;
      link.rejected <= link.write_pulse && link.pointer && !pair_ok;
    end

  // =====================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence key_first;
    clock_enable && link.write_pulse && !link.pointer && !link.overflow &&
      link.write_data == `WDT_KEY_FIRST;
  endsequence
  sequence key_second;
    clock_enable && link.write_pulse && link.pointer && !link.overflow &&
      link.write_data == `WDT_KEY_SECOND;
  endsequence
  sequence key_first_late;
    clock_enable && link.write_pulse && link.pointer && link.write_data == `WDT_KEY_FIRST;
  endsequence
  sequence key_second_early;
    clock_enable && link.write_pulse && !link.pointer && link.write_data == `WDT_KEY_SECOND;
  endsequence

  // bus writes are at least three cycles apart, so only the very next write lands in the window
  pair_accepted_a: assert property (key_first ##[3:5] key_second |=> link.accept)
    else $error("valid key pair not accepted");
  pointer_toggle_a: assert property (clock_enable && link.write_pulse && !link.overflow
                                     |=> link.pointer != $past(link.pointer))
    else $error("pointer did not toggle on write");
  overflow_ptr_a: assert property (clock_enable && link.overflow |=> !link.pointer)
    else $error("pointer not cleared by overflow");
  misplaced_key_a: assert property (key_first_late ##[3:5] key_second_early |=> !link.accept)
    else $error("out of step key pair accepted");
endmodule

// ==== watchdog_counter.sv ====
// 9-bit watchdog count advanced by the 256 Hz tap
// assumes tap_pulse is one cycle per tap period, gated by the clock enable
`timescale 1ns/100ps
`include "watchdog_regs.svh"
module watchdog_counter (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_enable,
  wdt_link_if.cnt  link
);
  import wdt_pkg::*;

  // =====================================================
  // run flag and count
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      link.running <= 1'b0;
    else if (clock_enable && link.accept)
      link.running <= 1'b1;

  // a clear in the tap cycle wins, so the full period restarts
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      link.count <= `WDT_COUNT_RESET;
    else if (clock_enable)
    begin
      if (link.accept)
        link.count <= `WDT_COUNT_RESET;
      else if (link.tap_pulse && link.running)
        link.count <= link.count + 9'h001;
    end

  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      link.overflow <= 1'b0;
    else if (clock_enable)
      link.overflow <= !link.accept && link.tap_pulse && link.running &&
                       link.count == `WDT_COUNT_MAX;

  // =====================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  tap_advance_a: assert property (clock_enable && link.running && link.tap_pulse && !link.accept
                                  |=> link.count == $past(link.count) + 9'h001)
    else $error("count did not advance on tap");
  stopped_hold_a: assert property (!link.running |-> link.count == `WDT_COUNT_RESET)
    else $error("count moved while stopped");
  clear_start_a: assert property (clock_enable && link.accept
                                  |=> link.running && link.count == `WDT_COUNT_RESET)
    else $error("accepted pair did not clear and run");
  wrap_irq_a: assert property (clock_enable && link.running && link.tap_pulse && !link.accept &&
                               link.count == `WDT_COUNT_MAX
                               |=> link.overflow && link.count == `WDT_COUNT_RESET)
    else $error("wrap did not raise overflow");
  keep_running_a: assert property (link.overflow |-> link.running ##1 link.running)
    else $error("counter stopped after overflow");
endmodule

// ==== watchdog_regs.svh ====
// register indices, field positions, reset values and timing counts of the watchdog
// assumes byte address = 4 * index on a 32-bit AXI4-Lite bus
`ifndef WATCHDOG_REGS_SVH
`define WATCHDOG_REGS_SVH

// =====================================================
// register indices (byte address is four times these)
`define WDT_IDX_UNLOCK   12'h09F
`define WDT_IDX_STATUS   12'h0A0
`define WDT_IDX_MASK     12'h0A1
`define WDT_IDX_STATE    12'h0A2

// =====================================================
// fields
`define WDT_EV_OVERFLOW  0
`define WDT_EV_ACCEPT    1
`define WDT_EV_REJECT    2
`define WDT_STATE_RUN    9
`define WDT_STATE_PTR    10

// =====================================================
// values and reset values
`define WDT_KEY_FIRST    4'h5
`define WDT_KEY_SECOND   4'hA
`define WDT_COUNT_MAX    9'h1FF
`define WDT_COUNT_RESET  9'h000
`define WDT_EVENT_RESET  3'h0
`define WDT_DATA_ZERO    32'h0000_0000

// =====================================================
// timing: overflow period in seconds, tap rate, taps per period
`define WDT_OVF_SECONDS  2
`define WDT_TAP_HZ       256
`define WDT_OVF_TAPS     (`WDT_OVF_SECONDS * `WDT_TAP_HZ)

`endif

// ==== watchdog_two_write_unlock.sv ====
// watchdog top: AXI4-Lite register slave, tap edge, event status, interrupt outputs
// assumes the 256 Hz tap comes from time base logic on this same clock
// assumes the bus stays idle while clock_enable is low
//
// Functional notes
// - the count is nine bits wide and steps once per 256 Hz tap period.
// - after system reset the count is held stopped until a start pair is taken.
// - system reset clears the count and the key pointer to zero.
// - a stopped count starts after 5H written at pointer 0, then 0AH at pointer 1.
// - every unlock port write with wstrb bit 0 set toggles the pointer; an overflow clears it and wins in the same cycle.
// - a running count is cleared to zero by the same 5H then 0AH pair.
// - a 5H written at pointer 1 is ignored and the following 0AH does not clear.
// - a wrap from the top value to zero raises the watchdog interrupt request.
// - the watchdog request has no software mask and outranks every other source.
// - at a 32768 Hz low-speed clock the overflow period from a clear is 2 seconds.
// - the unlock port is a four-bit write-only register used only for the keys.
`timescale 1ns/100ps
`include "watchdog_regs.svh"
module watchdog_two_write_unlock (
  input  wire logic           clock,
  input  wire logic           reset_n,
  input  wire logic           clock_enable,
  input  wire logic           time_base_tap_256hz,
  input  wire logic           awvalid,
  output var  logic           awready,
  input  wire wdt_pkg::addr_t awaddr,
  input  wire logic           wvalid,
  output var  logic           wready,
  input  wire wdt_pkg::data_t wdata,
  input  wire wdt_pkg::strb_t wstrb,
  output var  logic           bvalid,
  input  wire logic           bready,
  output var  wdt_pkg::resp_t bresp,
  input  wire logic           arvalid,
  output var  logic           arready,
  input  wire wdt_pkg::addr_t araddr,
  output var  logic           rvalid,
  input  wire logic           rready,
  output var  wdt_pkg::data_t rdata,
  output var  wdt_pkg::resp_t rresp,
  output var  logic           watchdog_irq,
  output var  logic           irq
);
  import wdt_pkg::*;

  wdt_link_if link ();

  addr_t       aw_addr;
  data_t       w_data;
  strb_t       w_strb;
  logic        aw_held;
  logic        w_held;
  logic        do_write;
  logic [11:0] widx;
  logic [11:0] ridx;
  logic        w_mapped;
  logic        r_mapped;
  logic        tap_prev;
  event_t      status;
  event_t      mask;
  event_t      w1c;
  event_t      events;
  event_t      next_status;
  data_t       next_rdata;

  // =====================================================
  // leaf modules
  unlock_sequencer sequencer (
    .clock        (clock),
    .reset_n      (reset_n),
    .clock_enable (clock_enable),
    .link         (link)
  );

  watchdog_counter counter (
    .clock        (clock),
    .reset_n      (reset_n),
    .clock_enable (clock_enable),
    .link         (link)
  );

  // =====================================================
  // address decode
  assign widx     = aw_addr[13:2];
  assign ridx     = araddr[13:2];
  assign w_mapped = aw_addr[15:14] == 2'h0 &&
                    (widx == `WDT_IDX_UNLOCK || widx == `WDT_IDX_STATUS ||
                     widx == `WDT_IDX_MASK || widx == `WDT_IDX_STATE);
  assign r_mapped = araddr[15:14] == 2'h0 &&
                    (ridx == `WDT_IDX_UNLOCK || ridx == `WDT_IDX_STATUS ||
                     ridx == `WDT_IDX_MASK || ridx == `WDT_IDX_STATE);
  assign do_write = aw_held && w_held && !bvalid;

  // =====================================================
  // write address and write data, taken in either order
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      awready <= 1'b1;
      aw_held <= 1'b0;
      aw_addr <= 16'h0000;
    end
    else if (clock_enable)
    begin
      if (awvalid && awready)
      begin
        awready <= 1'b0;
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      else if (bvalid && bready)
      begin
        awready <= 1'b1;
        aw_held <= 1'b0;
      end
    end

  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      wready <= 1'b1;
      w_held <= 1'b0;
      w_data <= `WDT_DATA_ZERO;
      w_strb <= 4'h0;
    end
    else if (clock_enable)
    begin
      if (wvalid && wready)
      begin
        wready <= 1'b0;
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      else if (bvalid && bready)
      begin
        wready <= 1'b1;
        w_held <= 1'b0;
      end
    end

  // =====================================================
  // write response
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end
    else if (clock_enable)
    begin
      if (do_write)
      begin
        bvalid <= 1'b1;
        bresp  <= w_mapped ? RESP_OKAY : RESP_DECERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end

  // a write to the unlock port only ever feeds the key sequencer
  assign link.write_pulse = clock_enable && do_write && w_mapped &&
                            widx == `WDT_IDX_UNLOCK && w_strb[0];
  assign link.write_data  = w_data[3:0];

  // =====================================================
  // tap edge: one step per tap period, whatever its duty cycle
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      tap_prev <= 1'b0;
    else if (clock_enable)
      tap_prev <= time_base_tap_256hz;

  assign link.tap_pulse = clock_enable && time_base_tap_256hz && !tap_prev;

  // =====================================================
  // mask register
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      mask <= `WDT_EVENT_RESET;
    else if (clock_enable && do_write && w_mapped && widx == `WDT_IDX_MASK && w_strb[0])
      mask <= w_data[2:0];

  // =====================================================
  // sticky status, write one to clear; a new event beats the clear
  always_comb
  begin
    events = `WDT_EVENT_RESET;
    events[`WDT_EV_OVERFLOW] = link.overflow;
    events[`WDT_EV_ACCEPT]   = link.accept;
    events[`WDT_EV_REJECT]   = link.rejected;
    w1c = `WDT_EVENT_RESET;
    if (do_write && w_mapped && widx == `WDT_IDX_STATUS && w_strb[0])
      w1c = w_data[2:0];
    next_status = (status & ~w1c) | events;
  end

  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      status <= `WDT_EVENT_RESET;
    else if (clock_enable)
      status <= next_status;

  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      irq <= 1'b0;
    else if (clock_enable)
      irq <= |(status & mask);

  // no mask touches this one; it is the top-priority request
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      watchdog_irq <= 1'b0;
    else if (clock_enable)
      watchdog_irq <= link.overflow;

  // =====================================================
  // read path
  always_comb
  begin
    next_rdata = `WDT_DATA_ZERO;
    if (r_mapped)
    begin
      case (ridx)
        `WDT_IDX_UNLOCK:
          next_rdata = `WDT_DATA_ZERO;
        `WDT_IDX_STATUS:
          next_rdata[2:0] = status;
        `WDT_IDX_MASK:
          next_rdata[2:0] = mask;
        `WDT_IDX_STATE:
        begin
          next_rdata[8:0]            = link.count;
          next_rdata[`WDT_STATE_RUN] = link.running;
          next_rdata[`WDT_STATE_PTR] = link.pointer;
        end
        default:
          next_rdata = `WDT_DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= `WDT_DATA_ZERO;
      rresp   <= RESP_OKAY;
    end
    else if (clock_enable)
    begin
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= next_rdata;
        rresp   <= r_mapped ? RESP_OKAY : RESP_DECERR;
      end
      else if (rvalid && rready)
      begin
        arready <= 1'b1;
        rvalid  <= 1'b0;
      end
    end

  // =====================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  reset_clear_a: assert property ($rose(reset_n) |-> link.count == `WDT_COUNT_RESET &&
                                  !link.pointer && !link.running)
    else $error("reset left count or pointer set");
  nmi_unmasked_a: assert property (clock_enable && link.overflow
                                   |=> watchdog_irq)
    else $error("watchdog request gated by mask");
  wo_read_a: assert property (clock_enable && arvalid && arready && ara_unlock()
                              |=> rvalid && rdata == `WDT_DATA_ZERO)
    else $error("unlock port read back nonzero");
  sticky_set_a: assert property (clock_enable && link.overflow
                                 |=> status[`WDT_EV_OVERFLOW])
    else $error("overflow event lost under clear");

  // bus answers stand until taken, and a busy channel refuses new requests
  bvalid_hold_a: assert property (bvalid && !bready |=> bvalid && bresp == $past(bresp))
    else $error("write response dropped before bready");
  rvalid_hold_a: assert property (rvalid && !rready |=> rvalid && rdata == $past(rdata))
    else $error("read data dropped before rready");
  aw_refused_a: assert property (bvalid |-> !awready && !wready)
    else $error("write channel open while response pending");
  ar_refused_a: assert property (rvalid |-> !arready)
    else $error("read address open while data pending");
  irq_masked_a: assert property (clock_enable && mask == `WDT_EVENT_RESET |=> !irq)
    else $error("level interrupt raised with all events masked");

  function automatic logic ara_unlock();
    return araddr[15:14] == 2'h0 && ridx == `WDT_IDX_UNLOCK;
  endfunction
endmodule

// ==== wdt_link_if.sv ====
// signals between the watchdog top, its key sequencer and its counter
// assumes all parties run on the same clock
`timescale 1ns/100ps
interface wdt_link_if;
  import wdt_pkg::*;
  logic    write_pulse;
  nibble_t write_data;
  logic    tap_pulse;
  logic    pointer;
  logic    accept;
  logic    rejected;
  logic    overflow;
  logic    running;
  count_t  count;
  modport seq (input write_pulse, write_data, overflow, output pointer, accept, rejected);
  modport cnt (input accept, tap_pulse, output overflow, running, count);
  modport top (output write_pulse, write_data, tap_pulse,
               input pointer, accept, rejected, overflow, running, count);
endinterface

// ==== wdt_pkg.sv ====
// types shared by the watchdog modules
// assumes nothing beyond a SystemVerilog compiler
package wdt_pkg;
  typedef logic [8:0]  count_t;
  typedef logic [3:0]  nibble_t;
  typedef logic [2:0]  event_t;
  typedef logic [15:0] addr_t;
  typedef logic [31:0] data_t;
  typedef logic [3:0]  strb_t;
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'h0,
    RESP_DECERR = 2'h3
  } resp_t;
endpackage
